// *** hdl/reset_boot_pkg.sv ***
// constants for the chip reset and boot-mode block
// Behaviour
// (RL1) Asserting the reset input puts core and peripherals into reset at once, with no clock.
// (RL2) The reset output stays low exactly 512 system clocks after the last reset source ends; the code holds it 515 (512 after internal release).
// (RL3) The clock output pin follows the internal system clock.
// (RL4) Boot config high with test low at reset exit selects serial flash programming mode.
// (RL5) In serial flash programming mode the programming port owns the on-chip flash.
// (RL6) The board holds the test pin low in normal operation.
// (RL7) After reset every programmable output takes the low drive-strength default.
// (RL8) A pin configured as general-purpose I/O has its pull-up enabled; the code drops it on gpio pins taken by the transceiver.
// (RL9) An external transceiver takes over the first two serial ports and the timer pins.
// (RL10) CAN transmit and receive have no dedicated pins, only multiplexed slots.
// (RL11) Boot pins are sampled once as internal reset releases and held until next reset.
package reset_boot_pkg;
	localparam int RESET_OUT_CYCLES = 512;
	localparam int DRIVE_BITS = 40;
	localparam logic [39:0] DRIVE_RESET = 40'h00_0000_0000;
	localparam int GPIO_PINS = 40;
	// pin indices inside the pad vectors
	localparam int UART0_LO = 8;
	localparam int UART1_HI = 15;
	localparam int TIMER16_LO = 20;
	localparam int TIMER16_HI = 23;
	localparam int CAN_TX_SLOT = 39;
	localparam int CAN_RX_SLOT = 38;
endpackage

// *** hdl/reset_and_boot_mode_control.sv ***
// chip reset sequencing, boot-mode capture and pad default control
`timescale 1ns/1ns
module reset_and_boot_mode_control #(
	parameter int HOLD_CYCLES = reset_boot_pkg::RESET_OUT_CYCLES,
	parameter int PINS = reset_boot_pkg::GPIO_PINS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reset_input_n,
	input wire logic boot_config_select,
	input wire logic test_pin,
	input wire logic ext_phy_select,
	input wire logic can_mux_enable,
	input wire logic drive_write,
	input wire logic [reset_boot_pkg::DRIVE_BITS-1:0] drive_wdata,
	input wire logic [PINS-1:0] gpio_mode,
	output logic core_reset_n,
	output logic reset_output_n,
	output logic system_clock_out,
	output logic serial_flash_prog_mode,
	output logic flash_owner_prog_port,
	output logic [reset_boot_pkg::DRIVE_BITS-1:0] drive_strength_select,
	output logic [PINS-1:0] pullup_enable,
	output logic [PINS-1:0] phy_takeover,
	output logic can_transmit_pin_en,
	output logic can_receive_pin_en
);
	localparam int CW = $clog2(HOLD_CYCLES + 1);

	// the pad decode reaches the CAN slots at the top of the pin vector
	if (HOLD_CYCLES < 1 || PINS <= reset_boot_pkg::CAN_TX_SLOT) begin : g_bad_params
		$error("reset_and_boot_mode_control: parameters out of range");
	end

	// both reset sources combine before the release synchroniser
	wire any_reset_n = rst_n & reset_input_n;

	logic sync1;
	logic sync2;
	logic [CW-1:0] hold_count;
	logic [CW-1:0] next_hold_count;
	logic sync2_d;
	logic prog_mode;

	// asserts asynchronously, releases through two flops
	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			sync1 <= 1'b0;
		else
			sync1 <= 1'b1;
	end

	// only this second stage reads the first, to let a metastable level settle
	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			sync2 <= 1'b0;
		else
			sync2 <= sync1;
	end

	// internal reset is immediate on assertion
	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			core_reset_n <= 1'b0; // RL1
		else
			core_reset_n <= sync2;
	end

	assign next_hold_count = (hold_count == CW'(HOLD_CYCLES)) ? hold_count : hold_count + 1'b1;

	// saturates, so the released pin stays high until the next reset
	wire next_reset_output_n = (next_hold_count == CW'(HOLD_CYCLES));

	// counts cycles from internal reset release
	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			hold_count <= '0;
		else if (core_reset_n)
			hold_count <= next_hold_count;
	end

	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			reset_output_n <= 1'b0;
		else if (core_reset_n)
			reset_output_n <= next_reset_output_n; // RL2
	end

	// boot straps sampled on the release edge only
	wire release_edge = sync2 & ~sync2_d;
	wire next_prog_mode = boot_config_select & ~test_pin; // RL4 RL6

	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			sync2_d <= 1'b0;
		else
			sync2_d <= sync2;
	end

	// later strap changes are ignored until the next reset
	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			prog_mode <= 1'b0;
		else if (release_edge)
			prog_mode <= next_prog_mode; // RL11
	end

	// pad defaults and takeover decode
	function automatic logic pin_in_range(input int pin, input int lo, input int hi);
		pin_in_range = (pin >= lo) && (pin <= hi);
	endfunction

	wire [PINS-1:0] phy_pins;
	wire [PINS-1:0] next_pullup_enable;
	wire next_can_tx_en;
	wire next_can_rx_en;
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_phy
			assign phy_pins[g] = ext_phy_select &&
				(pin_in_range(g, reset_boot_pkg::UART0_LO, reset_boot_pkg::UART1_HI) ||
				pin_in_range(g, reset_boot_pkg::TIMER16_LO, reset_boot_pkg::TIMER16_HI)); // RL9
		end
	endgenerate

	// pins handed to the transceiver are not gpio, so they lose the pull-up
	assign next_pullup_enable = gpio_mode & ~phy_pins; // RL8
	// only the multiplexed slots carry CAN; a slot in gpio use drops it
	assign next_can_tx_en = can_mux_enable & ~gpio_mode[reset_boot_pkg::CAN_TX_SLOT]; // RL10
	assign next_can_rx_en = can_mux_enable & ~gpio_mode[reset_boot_pkg::CAN_RX_SLOT]; // RL10

	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			serial_flash_prog_mode <= 1'b0;
		else
			serial_flash_prog_mode <= prog_mode;
	end

	// flash ownership follows the captured mode, one register per pin
	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			flash_owner_prog_port <= 1'b0;
		else
			flash_owner_prog_port <= prog_mode; // RL5
	end

	// low drive until software writes otherwise
	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			drive_strength_select <= reset_boot_pkg::DRIVE_RESET; // RL7
		else if (drive_write)
			drive_strength_select <= drive_wdata;
	end

	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			pullup_enable <= '0;
		else
			pullup_enable <= next_pullup_enable;
	end

	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			phy_takeover <= '0;
		else
			phy_takeover <= phy_pins;
	end

	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			can_transmit_pin_en <= 1'b0;
		else
			can_transmit_pin_en <= next_can_tx_en;
	end

	always_ff @(posedge mclk or negedge any_reset_n) begin
		if (!any_reset_n)
			can_receive_pin_en <= 1'b0;
		else
			can_receive_pin_en <= next_can_rx_en;
	end

	// clock copy must be a flop: toggle on both edges would need a second clock
	// so drive a divided-free copy via a negedge-inverted register pair
	logic clk_pos;
	logic clk_neg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			clk_pos <= 1'b0;
		else
			clk_pos <= ~clk_pos;
	end
	always_ff @(negedge mclk or negedge rst_n) begin
		if (!rst_n)
			clk_neg <= 1'b0;
		else
			clk_neg <= clk_pos;
	end
	// xor of the two toggles reproduces mclk with one flop delay
	// limitation: the xor can glitch if the two flops skew, keep them adjacent
	always_comb system_clock_out = clk_pos ^ clk_neg; // RL3
endmodule

// *** tb/rbm_checker_assertions.sv ***
// port assertions for the reset and boot-mode block
`timescale 1ns/1ns
module rbm_checker #(parameter int HOLD_CYCLES = 512) (
	input wire logic mclk, rst_n, reset_input_n, boot_config_select, test_pin,
	input wire logic core_reset_n, reset_output_n, serial_flash_prog_mode, flash_owner_prog_port,
	input wire logic ext_phy_select, can_mux_enable, can_transmit_pin_en,
	input wire logic [39:0] gpio_mode, drive_strength_select, phy_takeover
);
	int n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// edges since internal release
	always_ff @(posedge mclk or negedge core_reset_n)
		if (!core_reset_n) n <= 0;
		else n <= n + 1;
	AST_CORE: assert property (!reset_input_n |-> !core_reset_n) else $error("core");
	AST_HOLD: assert property (core_reset_n |-> reset_output_n == (n >= HOLD_CYCLES))
		else $error("hold");
	AST_MODE: assert property ($rose(core_reset_n) |=> serial_flash_prog_mode ==
		($past(boot_config_select, 2) && !$past(test_pin, 2))) else $error("mode");
	AST_OWN: assert property (flash_owner_prog_port == serial_flash_prog_mode)
		else $error("own");
	AST_DRV: assert property (!core_reset_n |=> drive_strength_select == 40'h0)
		else $error("drive");
	AST_KEEP: assert property ($past(core_reset_n, 2) && core_reset_n |->
		$stable(serial_flash_prog_mode)) else $error("keep");
	AST_PHY: assert property (core_reset_n ##1 core_reset_n |-> phy_takeover ==
		($past(ext_phy_select) ? 40'h00_00F0_FF00 : 40'h0)) else $error("phy");
	AST_CAN: assert property (core_reset_n ##1 core_reset_n |-> can_transmit_pin_en ==
		($past(can_mux_enable) && !$past(gpio_mode[39]))) else $error("can");
endmodule
bind reset_and_boot_mode_control rbm_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);

// *** tb/board_model.sv ***
// board side: reset switch and boot straps
`timescale 1ns/1ns
module board_model (input wire logic press, input wire logic [1:0] strap,
	output logic reset_input_n, boot_config_select, test_pin);
	assign reset_input_n = !press;
	// straps held steady by the bench across reset exit
	assign {test_pin, boot_config_select} = strap;
endmodule

// *** tb/reset_and_boot_mode_control_test.sv ***
// bench for the reset and boot-mode block
`timescale 1ns/1ns
module reset_and_boot_mode_control_test;
	logic mclk = 0, rst_n = 0, press = 1, ext_phy_select = 0, can_mux_enable = 0, drive_write = 0;
	logic reset_input_n, boot_config_select, test_pin, core_reset_n, reset_output_n, a;
	logic system_clock_out, serial_flash_prog_mode, flash_owner_prog_port;
	logic can_transmit_pin_en, can_receive_pin_en;
	logic [1:0] strap = 0;
	logic [39:0] drive_wdata = 0, gpio_mode = 0, drive_strength_select, pullup_enable, phy_takeover;
	int failures = 0, n_compared = 0, n;
	always #10 mclk = ~mclk;
	board_model bm (.*);
	// short hold keeps the run brief; 3 sync edges come before it
	reset_and_boot_mode_control #(.HOLD_CYCLES(8)) dut (.*);
	task chk(input logic [39:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("%0d compared, %0d bad", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task boot(input logic [1:0] s);
		@(posedge mclk) press <= 1;
		strap <= s;
		#1 chk(core_reset_n, 0);
		@(posedge mclk) press <= 0;
		for (n = 0; n < 99 && !reset_output_n; n++) @(posedge mclk) #1;
		chk(40'(n), 11);
		chk(serial_flash_prog_mode, s == 1);
		chk(flash_owner_prog_port, s == 1);
		chk(drive_strength_select, 0);
		@(posedge mclk) strap <= ~s;
		repeat (3) @(posedge mclk);
		#1 chk(serial_flash_prog_mode, s == 1);
		$display("boot %b done", s);
	endtask
	task pads;
		@(posedge mclk) #1 a = system_clock_out;
		@(negedge mclk) #1 chk(a ^ system_clock_out, 1);
		@(posedge mclk) gpio_mode <= 40'hC0_0000_FF00;
		ext_phy_select <= 1;
		can_mux_enable <= 1;
		drive_write <= 1;
		drive_wdata <= 40'hA5_0000_0001;
		@(posedge mclk) drive_write <= 0;
		@(posedge mclk) #1 chk(drive_strength_select, 40'hA5_0000_0001);
		chk(phy_takeover, 40'h00_00F0_FF00);
		chk(pullup_enable, 40'hC0_0000_0000);
		chk({can_transmit_pin_en, can_receive_pin_en}, 0);
		@(posedge mclk) gpio_mode <= 0;
		repeat (2) @(posedge mclk);
		#1 chk({can_transmit_pin_en, can_receive_pin_en}, 3);
		$display("pads done");
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		boot(2'b01);
		boot(2'b11);
		boot(2'b00);
		pads;
		finish_test;
	end
	initial begin
		#20000 failures++;
		finish_test;
	end
endmodule
